// File: hw/twc_pkg.sv
// What this block does
// R1 - take 22-bit addresses from processor or I/O master through one lookup path
// R2 - address bits 21-10 field, 9-2 index, bit 1 word, bit 0 byte
// R3 - index addresses a 256-entry tag store, 30 bits, one tag per group
// R4 - each tag holds a 12-bit field, a valid bit and two parity bits
// R5 - two comparators match stored fields against the top 12 address bits
// R6 - parity of both tags checked in the same cycle as the compares
// R7 - group hits only when its field matches and its valid bit is set
// R8 - hit also needs clean parity, otherwise the access is a miss
// R9 - data word chosen by index, address bit 1 and hitting group
// R10 - read hit returns the word to whichever requester asked
// R11 - read miss fetches a two-word block at the top 20 address bits
// R12 - replaced block: index picks set, internal random bit picks group
// R13 - arriving block written to data store while requested word is returned
// R14 - fill writes the address field into the chosen tag with valid set
// R15 - write hit updates only the addressed word or byte of hitting group
// R16 - every write hit is also written through to main memory
// R17 - write miss writes main memory only, stores untouched
// R18 - power-up sequence clears every valid bit before accesses begin
// R19 - same sequence loads all other store bits with correct-parity patterns
// R20 - sweep steps all 256 indexes, one per cycle, requests held off meanwhile
// R21 - tag parity error sets a sticky per-group error flag
package twc_pkg;

  // ****************
  // address layout
  // ****************
  localparam int ADDR_W = 22;
  localparam int FIELD_HI = 21;
  localparam int FIELD_LO = 10;
  localparam int INDEX_HI = 9;
  localparam int INDEX_LO = 2;
  localparam int WORD_BIT = 1;
  localparam int BYTE_BIT = 0;
  localparam int FIELD_W = 12;
  localparam int INDEX_W = 8;
  localparam int BLOCK_LO = 2;

  // ****************
  // store layout
  // ****************
  localparam int SETS = 256;
  localparam int GROUPS = 2;
  localparam int TAG_W = 15;
  localparam int ENTRY_W = 30;
  localparam int TAG_VALID_BIT = 12;
  localparam int TAG_PAR_LO = 13;
  localparam int WORD_W = 16;
  localparam int DATA_WORDS = 1024;
  localparam int BLOCK_W = 32;

  // ****************
  // reset and sweep values
  // ****************
  localparam logic [7:0] INIT_FIRST = 8'h00;
  localparam logic [7:0] INIT_LAST = 8'hFF;
  localparam logic [29:0] ENTRY_CLEAN = 30'h0000_0000;
  localparam logic [15:0] WORD_CLEAN = 16'h0000;
  localparam logic [15:0] LFSR_SEED = 16'hACE1;

  typedef enum logic [2:0] {
    S_INIT,
    S_IDLE,
    S_LOOKUP,
    S_MEM_WRITE,
    S_FILL_REQ,
    S_FILL_WAIT
  } twc_state_t;

  // even parity: low bit over field[5:0], high bit over valid and field[11:6]
  function automatic logic [1:0] twc_tag_parity(input logic valid, input logic [11:0] field);
    twc_tag_parity = {^{valid, field[11:6]}, ^field[5:0]};
  endfunction

endpackage

// File: hw/twc_tag_check.sv
`timescale 1ns/100ps
module twc_tag_check (
  // stored set and incoming field
  input wire logic [29:0] i_entry,
  input wire logic [11:0] i_field,
  // per-group results
  output logic [1:0] o_hit,
  output logic [1:0] o_perr
);

  // ****************
  // one comparator and parity checker per group
  // ****************
  for (genvar g = 0; g < twc_pkg::GROUPS; g++) begin : g_grp
    logic [14:0] tag;
    logic match;
    assign tag = i_entry[g*twc_pkg::TAG_W +: twc_pkg::TAG_W];
    assign match = (tag[11:0] == i_field); // R5
    // parity is checked alongside the compare, not after it
    assign o_perr[g] = (tag[14:13] != twc_pkg::twc_tag_parity(tag[12], tag[11:0])); // R6
    assign o_hit[g] = match && tag[twc_pkg::TAG_VALID_BIT] && !o_perr[g]; // R7 R8
  end

endmodule // twc_tag_check

// File: hw/twc_random.sv
`timescale 1ns/100ps
module twc_random (
  // clock and reset
  input wire logic i_clock,
  input wire logic i_arst_n,
  // replacement choice
  output logic o_bit
);

  typedef struct packed {
    logic [15:0] lfsr;
  } twc_random_state_t;

  twc_random_state_t s;
  twc_random_state_t next_s;

  // ****************
  // free-running lfsr, taps 16 14 13 11
  // ****************
  always_comb begin
    next_s = s;
    next_s.lfsr = {s.lfsr[14:0], s.lfsr[15] ^ s.lfsr[13] ^ s.lfsr[12] ^ s.lfsr[10]};
  end

  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      s.lfsr <= twc_pkg::LFSR_SEED;
    end else begin
      s <= next_s;
    end
  end

  assign o_bit = s.lfsr[0]; // R12

endmodule // twc_random

// File: hw/twc_cache.sv
`timescale 1ns/100ps
module twc_cache (
  // clock and reset
  input wire logic i_clock,
  input wire logic i_arst_n,
  // requester side
  input wire logic i_req_valid,
  input wire logic i_req_src,
  input wire logic i_req_write,
  input wire logic i_req_byte,
  input wire logic [21:0] i_req_addr,
  input wire logic [15:0] i_req_wdata,
  output logic o_req_ready,
  output logic o_rsp_valid,
  output logic o_rsp_src,
  output logic o_rsp_write,
  output logic [15:0] o_rsp_data,
  // main memory side
  output logic o_mem_valid,
  output logic o_mem_write,
  output logic o_mem_byte,
  output logic [21:0] o_mem_addr,
  output logic [15:0] o_mem_wdata,
  input wire logic i_mem_ready,
  input wire logic i_mem_rvalid,
  input wire logic [31:0] i_mem_rdata,
  // status
  input wire logic [1:0] i_err_clear,
  output logic [1:0] o_parity_err,
  output logic o_init_busy
);

  typedef struct packed {
    twc_pkg::twc_state_t state;
    logic [7:0] init_idx;
    logic [21:0] addr;
    logic write;
    logic byte_op;
    logic src;
    logic [15:0] wdata;
    logic group;
    logic rsp_valid;
    logic rsp_src;
    logic rsp_write;
    logic [15:0] rsp_data;
    logic mem_valid;
    logic mem_write;
    logic [1:0] perr;
  } twc_cache_state_t;

  twc_cache_state_t s;
  twc_cache_state_t next_s;

  // ****************
  // stores
  // ****************
  logic [29:0] tag_mem [0:twc_pkg::SETS-1]; // R3
  logic [15:0] fast_data_memory [0:twc_pkg::DATA_WORDS-1];

  logic [7:0] idx;
  logic [11:0] field;
  logic word_sel;
  logic [29:0] entry;
  logic [1:0] hit;
  logic [1:0] perr_now;
  logic hit_any;
  logic hit_grp;
  logic [15:0] rd_word;
  logic [15:0] merged;
  logic rnd;
  logic tag_we;
  logic [7:0] tag_widx;
  logic [29:0] tag_wdata;
  logic [14:0] new_tag;
  logic [7:0] dat_idx;
  logic [3:0] dat_we;
  logic [3:0][15:0] dat_wd;
  logic [1:0] perr_set;

  // ****************
  // lookup path
  // ****************
  assign idx = s.addr[twc_pkg::INDEX_HI:twc_pkg::INDEX_LO]; // R2 R3
  assign field = s.addr[twc_pkg::FIELD_HI:twc_pkg::FIELD_LO]; // R2
  assign word_sel = s.addr[twc_pkg::WORD_BIT];
  assign entry = tag_mem[idx];

  twc_tag_check u_tag_check (
    .i_entry(entry),
    .i_field(field),
    .o_hit(hit),
    .o_perr(perr_now)
  );

  twc_random u_random (
    .i_clock(i_clock),
    .i_arst_n(i_arst_n),
    .o_bit(rnd)
  );

  assign hit_any = |hit;
  // both groups hitting cannot happen without corruption; group 0 then wins
  assign hit_grp = !hit[0];
  assign rd_word = fast_data_memory[{hit_grp, idx, word_sel}]; // R9
  assign new_tag = {twc_pkg::twc_tag_parity(1'b1, field), 1'b1, field}; // R4 R14

  // byte lane follows address bit 0; the other lane keeps the cached value
  always_comb begin
    merged = s.wdata;
    if (s.byte_op) begin
      if (s.addr[twc_pkg::BYTE_BIT]) begin
        merged = {s.wdata[15:8], rd_word[7:0]};
      end else begin
        merged = {rd_word[15:8], s.wdata[7:0]};
      end
    end
  end

  // ****************
  // control
  // ****************
  always_comb begin
    next_s = s;
    next_s.rsp_valid = 1'b0;
    tag_we = 1'b0;
    tag_widx = idx;
    tag_wdata = entry;
    dat_idx = idx;
    dat_we = 4'h0;
    dat_wd = {4{s.wdata}};
    perr_set = 2'h0;
    unique case (s.state)
      twc_pkg::S_INIT: begin
        // one index per cycle, all four words and both tags cleaned
        tag_we = 1'b1; // R18
        tag_widx = s.init_idx;
        tag_wdata = twc_pkg::ENTRY_CLEAN; // R19
        dat_idx = s.init_idx;
        dat_we = 4'hF;
        dat_wd = {4{twc_pkg::WORD_CLEAN}}; // R19
        if (s.init_idx == twc_pkg::INIT_LAST) begin
          next_s.state = twc_pkg::S_IDLE; // R20
        end else begin
          next_s.init_idx = s.init_idx + 8'h01; // R20
        end
      end
      twc_pkg::S_IDLE: begin
        if (i_req_valid) begin
          next_s.addr = i_req_addr; // R1
          next_s.src = i_req_src;
          next_s.write = i_req_write;
          next_s.byte_op = i_req_byte;
          next_s.wdata = i_req_wdata;
          next_s.state = twc_pkg::S_LOOKUP;
        end
      end
      twc_pkg::S_LOOKUP: begin
        perr_set = perr_now; // R21
        if (s.write) begin
          if (hit_any) begin
            dat_we[{hit_grp, word_sel}] = 1'b1; // R15
            dat_wd[{hit_grp, word_sel}] = merged; // R15
          end
          next_s.mem_valid = 1'b1; // R16 R17
          next_s.mem_write = 1'b1;
          next_s.state = twc_pkg::S_MEM_WRITE;
        end else if (hit_any) begin
          next_s.rsp_valid = 1'b1; // R10
          next_s.rsp_src = s.src;
          next_s.rsp_write = 1'b0;
          next_s.rsp_data = rd_word; // R9 R10
          next_s.state = twc_pkg::S_IDLE;
        end else begin
          next_s.group = rnd; // R12
          next_s.mem_valid = 1'b1; // R11
          next_s.mem_write = 1'b0;
          next_s.state = twc_pkg::S_FILL_REQ;
        end
      end
      twc_pkg::S_MEM_WRITE: begin
        if (i_mem_ready) begin
          next_s.mem_valid = 1'b0;
          next_s.rsp_valid = 1'b1;
          next_s.rsp_src = s.src;
          next_s.rsp_write = 1'b1;
          next_s.state = twc_pkg::S_IDLE;
        end
      end
      twc_pkg::S_FILL_REQ: begin
        if (i_mem_ready) begin
          next_s.mem_valid = 1'b0;
          next_s.state = twc_pkg::S_FILL_WAIT;
        end
      end
      twc_pkg::S_FILL_WAIT: begin
        if (i_mem_rvalid) begin
          dat_we[{s.group, 1'b0}] = 1'b1; // R13
          dat_we[{s.group, 1'b1}] = 1'b1; // R13
          dat_wd[{s.group, 1'b0}] = i_mem_rdata[15:0];
          dat_wd[{s.group, 1'b1}] = i_mem_rdata[31:16];
          tag_we = 1'b1; // R14
          if (s.group) begin
            tag_wdata = {new_tag, entry[14:0]}; // R14
          end else begin
            tag_wdata = {entry[29:15], new_tag}; // R14
          end
          next_s.rsp_valid = 1'b1; // R13
          next_s.rsp_src = s.src;
          next_s.rsp_write = 1'b0;
          next_s.rsp_data = word_sel ? i_mem_rdata[31:16] : i_mem_rdata[15:0]; // R13
          next_s.state = twc_pkg::S_IDLE;
        end
      end
    endcase
    // a new error in the clearing cycle survives the clear
    next_s.perr = (s.perr & ~i_err_clear) | perr_set; // R21
  end

  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      s.state <= twc_pkg::S_INIT;
      s.init_idx <= twc_pkg::INIT_FIRST;
      s.addr <= 22'h00_0000;
      s.write <= 1'b0;
      s.byte_op <= 1'b0;
      s.src <= 1'b0;
      s.wdata <= 16'h0000;
      s.group <= 1'b0;
      s.rsp_valid <= 1'b0;
      s.rsp_src <= 1'b0;
      s.rsp_write <= 1'b0;
      s.rsp_data <= 16'h0000;
      s.mem_valid <= 1'b0;
      s.mem_write <= 1'b0;
      s.perr <= 2'h0;
    end else begin
      s <= next_s;
    end
  end

  // stores have no reset; the power-up sweep gives them clean contents
  always_ff @(posedge i_clock) begin
    if (tag_we) begin
      tag_mem[tag_widx] <= tag_wdata;
    end
    for (int k = 0; k < 4; k++) begin
      if (dat_we[k]) begin
        fast_data_memory[{k[1], dat_idx, k[0]}] <= dat_wd[k];
      end
    end
  end

  // ****************
  // outputs
  // ****************
  assign o_req_ready = (s.state == twc_pkg::S_IDLE); // R20
  assign o_rsp_valid = s.rsp_valid;
  assign o_rsp_src = s.rsp_src;
  assign o_rsp_write = s.rsp_write;
  assign o_rsp_data = s.rsp_data;
  assign o_mem_valid = s.mem_valid;
  assign o_mem_write = s.mem_write;
  assign o_mem_byte = s.byte_op & s.mem_write;
  // block fetch drops the word and byte bits
  assign o_mem_addr = s.mem_write ? s.addr : {s.addr[21:twc_pkg::BLOCK_LO], 2'b00}; // R11
  assign o_mem_wdata = s.wdata;
  assign o_parity_err = s.perr;
  assign o_init_busy = (s.state == twc_pkg::S_INIT);

endmodule // twc_cache

// File: verification/twc_cache_properties.sv
`timescale 1ns/100ps
module twc_cache_properties (
  // watched ports
  input wire logic i_clock,
  input wire logic i_arst_n,
  input wire logic i_req_valid,
  input wire logic i_req_src,
  input wire logic i_req_write,
  input wire logic o_req_ready,
  input wire logic o_rsp_valid,
  input wire logic o_rsp_src,
  input wire logic o_rsp_write,
  input wire logic o_mem_valid,
  input wire logic o_mem_write,
  input wire logic [21:0] o_mem_addr,
  input wire logic i_mem_ready,
  input wire logic i_mem_rvalid,
  input wire logic o_init_busy
);
  // ****************
  // helper state
  // ****************
  logic [8:0] busy_cnt;
  logic src_q;
  logic fill_q;
  // fill_q marks the wait for a block, so stray rvalid pulses are not judged
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      busy_cnt <= 9'h000;
      src_q <= 1'b0;
      fill_q <= 1'b0;
    end else begin
      if (o_init_busy) busy_cnt <= busy_cnt + 9'h001;
      if (i_req_valid && o_req_ready) src_q <= i_req_src;
      if (o_mem_valid && !o_mem_write && i_mem_ready) fill_q <= 1'b1;
      else if (i_mem_rvalid) fill_q <= 1'b0;
    end
  end
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_arst_n);
  sweep_ready_a: assert property (o_init_busy |-> !o_req_ready) else $error("ready in sweep");
  sweep_len_a: assert property ($fell(o_init_busy) |-> busy_cnt == 9'h100) else $error("sweep length");
  read_path_a: assert property (i_req_valid && o_req_ready && !i_req_write |=> !o_req_ready ##1
    (o_rsp_valid || (o_mem_valid && !o_mem_write))) else $error("read lookup");
  write_thru_a: assert property (i_req_valid && o_req_ready && i_req_write |=> ##1 o_mem_valid && o_mem_write)
    else $error("no write cycle");
  block_addr_a: assert property (o_mem_valid && !o_mem_write |-> o_mem_addr[1:0] == 2'b00)
    else $error("block address");
  mem_hold_a: assert property (o_mem_valid && !i_mem_ready |=> o_mem_valid && $stable(o_mem_addr))
    else $error("memory request dropped");
  write_ack_a: assert property (o_mem_valid && o_mem_write && i_mem_ready |=>
    !o_mem_valid && o_rsp_valid && o_rsp_write) else $error("write completion");
  fill_rsp_a: assert property (fill_q && i_mem_rvalid |=> o_rsp_valid && !o_rsp_write)
    else $error("fill response");
  rsp_src_a: assert property (o_rsp_valid |-> o_rsp_src == src_q) else $error("wrong requester");
  rsp_pulse_a: assert property (o_rsp_valid |=> !o_rsp_valid) else $error("response too long");
  cover property ($fell(o_init_busy));
  cover property (fill_q && i_mem_rvalid);
  cover property (o_mem_valid && o_mem_write && i_mem_ready);
endmodule // twc_cache_properties

bind twc_cache twc_cache_properties i_props (.i_clock(i_clock), .i_arst_n(i_arst_n),
  .i_req_valid(i_req_valid), .i_req_src(i_req_src), .i_req_write(i_req_write), .o_req_ready(o_req_ready),
  .o_rsp_valid(o_rsp_valid), .o_rsp_src(o_rsp_src), .o_rsp_write(o_rsp_write), .o_mem_valid(o_mem_valid),
  .o_mem_write(o_mem_write), .o_mem_addr(o_mem_addr), .i_mem_ready(i_mem_ready),
  .i_mem_rvalid(i_mem_rvalid), .o_init_busy(o_init_busy));

// File: verification/twc_mem_model.sv
`timescale 1ns/100ps
module twc_mem_model (
  // clock, reset and pace
  input wire logic i_clock,
  input wire logic i_arst_n,
  input wire logic i_slow,
  // cache memory port
  input wire logic i_valid,
  input wire logic i_write,
  input wire logic i_byte,
  input wire logic [21:0] i_addr,
  input wire logic [15:0] i_wdata,
  output logic o_ready,
  output logic o_rvalid,
  output logic [31:0] o_rdata
);
  logic [15:0] mem [int];
  logic [15:0] w;
  logic [21:0] raddr;
  logic pend;
  int cnt;
  // unwritten words read as a pattern of their address
  function automatic logic [15:0] rd(input logic [21:0] a);
    rd = mem.exists(int'(a[21:1])) ? mem[int'(a[21:1])] : a[16:1] ^ 16'h3C3C;
  endfunction
  always @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_ready <= 1'b0;
      o_rvalid <= 1'b0;
      o_rdata <= 32'h0000_0000;
      pend <= 1'b0;
      cnt <= 0;
    end else begin
      o_ready <= 1'b0;
      o_rvalid <= 1'b0;
      // data lines are not held outside the pulse
      o_rdata <= ~o_rdata;
      if (i_valid && o_ready) begin
        w = rd(i_addr);
        if (!i_byte) w = i_wdata;
        else if (i_addr[0]) w[15:8] = i_wdata[15:8];
        else w[7:0] = i_wdata[7:0];
        if (i_write) mem[int'(i_addr[21:1])] = w;
        else pend <= 1'b1;
        raddr <= i_addr;
      end else if (i_valid && !pend) begin
        if (cnt >= (i_slow ? 3 : 0)) o_ready <= 1'b1;
        cnt <= (cnt >= (i_slow ? 3 : 0)) ? 0 : cnt + 1;
      end
      if (pend) begin
        if (cnt >= (i_slow ? 4 : 0)) begin
          o_rvalid <= 1'b1;
          o_rdata <= {rd(raddr | 22'h000002), rd(raddr)};
          pend <= 1'b0;
        end
        cnt <= (cnt >= (i_slow ? 4 : 0)) ? 0 : cnt + 1;
      end
    end
  end
endmodule // twc_mem_model

// File: verification/twc_cache_tb.sv
`timescale 1ns/100ps
module twc_cache_tb;
  logic i_clock, i_arst_n, i_req_valid, i_req_src, i_req_write, i_req_byte, i_slow;
  logic o_req_ready, o_rsp_valid, o_rsp_src, o_rsp_write, o_init_busy;
  logic o_mem_valid, o_mem_write, o_mem_byte, i_mem_ready, i_mem_rvalid, mw_byte;
  logic [21:0] i_req_addr, o_mem_addr, mw_addr, mr_addr;
  logic [15:0] i_req_wdata, o_rsp_data, o_mem_wdata, mw_data, q;
  logic [31:0] i_mem_rdata;
  logic [1:0] i_err_clear, o_parity_err;
  int n_errors, checks, n_mem, n0;
  localparam logic [21:0] A = 22'h012344;
  localparam logic [21:0] C = 22'h012744;
  twc_cache i_dut (.i_clock(i_clock), .i_arst_n(i_arst_n), .i_req_valid(i_req_valid), .i_req_src(i_req_src),
    .i_req_write(i_req_write), .i_req_byte(i_req_byte), .i_req_addr(i_req_addr), .i_req_wdata(i_req_wdata),
    .o_req_ready(o_req_ready), .o_rsp_valid(o_rsp_valid), .o_rsp_src(o_rsp_src), .o_rsp_write(o_rsp_write),
    .o_rsp_data(o_rsp_data), .o_mem_valid(o_mem_valid), .o_mem_write(o_mem_write), .o_mem_byte(o_mem_byte),
    .o_mem_addr(o_mem_addr), .o_mem_wdata(o_mem_wdata), .i_mem_ready(i_mem_ready), .i_mem_rvalid(i_mem_rvalid),
    .i_mem_rdata(i_mem_rdata), .i_err_clear(i_err_clear), .o_parity_err(o_parity_err), .o_init_busy(o_init_busy));
  twc_mem_model i_mem (.i_clock(i_clock), .i_arst_n(i_arst_n), .i_slow(i_slow), .i_valid(o_mem_valid),
    .i_write(o_mem_write), .i_byte(o_mem_byte), .i_addr(o_mem_addr), .i_wdata(o_mem_wdata),
    .o_ready(i_mem_ready), .o_rvalid(i_mem_rvalid), .o_rdata(i_mem_rdata));
  initial begin
    i_clock = 1'b0;
    forever #12.5 i_clock = ~i_clock;
  end
  always @(posedge i_clock) begin
    if (o_mem_valid && i_mem_ready) begin
      n_mem++;
      if (o_mem_write) mw_byte = o_mem_byte;
      if (o_mem_write) mw_addr = o_mem_addr;
      if (o_mem_write) mw_data = o_mem_wdata;
      else mr_addr = o_mem_addr;
    end
  end
  function automatic logic [15:0] pat(input logic [21:0] a);
    pat = a[16:1] ^ 16'h3C3C;
  endfunction
  task automatic cmp(input logic [47:0] got, input logic [47:0] exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic req(input logic s, input logic w, input logic b, input logic [21:0] a, input logic [15:0] d);
    int n;
    n = 0;
    @(posedge i_clock);
    i_req_valid <= 1'b1;
    i_req_src <= s;
    i_req_write <= w;
    i_req_byte <= b;
    i_req_addr <= a;
    i_req_wdata <= d;
    do begin @(posedge i_clock); n++; end while (o_req_ready !== 1'b1 && n < 50);
    i_req_valid <= 1'b0;
    do begin @(posedge i_clock); n++; end while (o_rsp_valid !== 1'b1 && n < 100);
    q = o_rsp_data;
    // a missing response shows up here as a mismatch, not as stale fields
    cmp({o_rsp_valid, o_rsp_src, o_rsp_write}, {1'b1, s, w});
  endtask
  task automatic t_sweep;
    int n;
    n = 0;
    do begin @(posedge i_clock); n++; end while (o_req_ready !== 1'b1 && n < 400);
    // ready is first seen at the edge after the 256th sweep step
    cmp(n, 256 + 1);
  endtask
  task automatic t_fill;
    n0 = n_mem;
    req(1'b0, 1'b0, 1'b0, A, 16'h0000);
    cmp(q, pat(A));
    cmp(mr_addr, {A[21:2], 2'b00});
    req(1'b1, 1'b0, 1'b0, A | 22'h000002, 16'h0000);
    cmp(q, pat(A | 22'h000002));
    cmp(n_mem - n0, 1);
  endtask
  task automatic t_write_hit;
    n0 = n_mem;
    req(1'b0, 1'b1, 1'b0, A, 16'h1234);
    cmp({mw_byte, mw_addr, mw_data}, {1'b0, A, 16'h1234});
    req(1'b1, 1'b1, 1'b1, A | 22'h000001, 16'hAB00);
    cmp({mw_byte, mw_addr, mw_data}, {1'b1, A | 22'h000001, 16'hAB00});
    req(1'b0, 1'b0, 1'b0, A, 16'h0000);
    cmp(q, 16'hAB34);
    req(1'b0, 1'b1, 1'b1, A, 16'h00CD);
    req(1'b1, 1'b0, 1'b0, A, 16'h0000);
    cmp(q, 16'hABCD);
    cmp(n_mem - n0, 3);
  endtask
  task automatic t_write_miss;
    i_slow <= 1'b1;
    n0 = n_mem;
    req(1'b0, 1'b1, 1'b0, C, 16'h5555);
    req(1'b0, 1'b0, 1'b0, A, 16'h0000);
    cmp(q, 16'hABCD);
    cmp(n_mem - n0, 1);
    req(1'b1, 1'b0, 1'b0, C, 16'h0000);
    cmp(q, 16'h5555);
    // hit or refetch, memory must agree with the cached copy
    req(1'b0, 1'b0, 1'b0, A, 16'h0000);
    cmp(q, 16'hABCD);
    req(1'b1, 1'b0, 1'b0, 22'h000106, 16'h0000);
    cmp(q, pat(22'h000106));
    i_err_clear <= 2'b11;
    cmp(o_parity_err, 2'b00);
  endtask
  task automatic test_done;
    $display("checks %0d n_errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    {i_arst_n, i_req_valid, i_req_src, i_req_write, i_req_byte, i_slow} = 6'h00;
    i_req_addr = 22'h000000;
    i_req_wdata = 16'h0000;
    i_err_clear = 2'b00;
    repeat (4) @(posedge i_clock);
    i_arst_n <= 1'b1;
    t_sweep;
    t_fill;
    t_write_hit;
    t_write_miss;
    test_done;
  end
  // the whole run needs well under 1000 cycles
  initial begin
    repeat (5000) @(posedge i_clock);
    n_errors++;
    test_done;
  end
endmodule // twc_cache_tb
